// ---- common/lcd_ext_pkg.sv ----
// shared constants and types for the display extended-command and pixel-memory access block
`default_nettype none
package lcd_ext_pkg;
  // command opcodes
  localparam logic [7:0] OP_MUX        = 8'hA8;
  localparam logic [7:0] OP_BIAS_TC    = 8'hA9;
  localparam logic [6:0] OP_QBIAS_TOP  = 7'h55;
  localparam logic [7:0] OP_PHASE      = 8'hD2;
  localparam logic [7:0] OP_OFFSET     = 8'hD3;
  localparam logic [7:0] OP_RMW_ENTER  = 8'hE0;
  localparam logic [7:0] OP_RMW_EXIT   = 8'hEE;
  localparam logic [7:0] OP_SOFT_RESET = 8'hE2;
  localparam logic [3:0] OP_COL_LO     = 4'h0;
  localparam logic [3:0] OP_COL_HI     = 4'h1;
  localparam logic [3:0] OP_PAGE       = 4'hB;
  // power-on values
  localparam logic [5:0] MUX_RST       = 6'h3F;
  localparam logic [1:0] BIAS_RST      = 2'h2;
  localparam logic [2:0] SLOPE_RST     = 3'h0;
  localparam logic [2:0] OSC_RST       = 3'h3;
  localparam logic       QBIAS_RST     = 1'h0;
  localparam logic [1:0] PHASE_RST     = 2'h2;
  localparam logic [5:0] OFFSET_RST    = 6'h00;
  // field values and positions
  localparam logic [1:0] BIAS_PROHIB   = 2'h3;
  localparam logic [4:0] PHASE_LOW     = 5'h02;
  localparam int         SLOPE_LSB     = 2;
  localparam int         OSC_LSB       = 5;
  localparam int         PHASE_LSB     = 5;
  localparam logic [5:0] MUX_FIELD_64  = 6'h3E;
  localparam logic [5:0] ROWS_FULL     = 6'h3E;
  localparam logic [7:0] COL_MAX       = 8'h83;
  localparam logic [3:0] PAGE_MAX      = 4'h8;
  localparam logic [3:0] OVL_ICON_ON   = 4'h3;
  localparam logic [3:0] OVL_ICON_OFF  = 4'h1;
  localparam int         STAT_BUSY_BIT = 7;
  // arbitrary identification nibble, not tied to any real part
  localparam logic [3:0] DEV_ID        = 4'h5;
  // host port flavours
  localparam logic [1:0] IF_6800       = 2'h0;
  localparam logic [1:0] IF_8080       = 2'h1;
  localparam logic [1:0] IF_SERIAL     = 2'h2;
  // timing: phase-step divider in oscillator cycles
  localparam int         PHASE_DIV     = 1000;

  typedef enum logic [2:0] {ST_CMD, ST_MUX, ST_BIAS_TC, ST_PHASE, ST_OFFSET} cmd_state_e;
endpackage
`default_nettype wire

// ---- hw/pix_mem.sv ----
// display pixel memory: one write port, registered read data
`default_nettype none
module pix_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input  wire logic          sys_clk_in,
  // write
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  // read
  output logic      [DW-1:0] rdata_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: memory content is undefined after power-on, as in the panel ram
  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule
`default_nettype wire

// ---- hw/lcd_ext_cmd.sv ----
// extended configuration command decoder with pixel-memory read/write access
`default_nettype none
module lcd_ext_cmd #(
  parameter int PHASE_DIV_P = lcd_ext_pkg::PHASE_DIV
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  // host transfer, one-cycle strobe per completed access
  input  wire logic       xfer_stb_in,
  input  wire logic [1:0] port_sel_in,
  input  wire logic       dc_in,
  input  wire logic       rw_in,
  input  wire logic       rd_n_in,
  input  wire logic [7:0] data_in,
  // read answer
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  output logic            busy_out,
  // static icon request from the indicator logic
  input  wire logic       icon_on_in,
  // extended settings
  output logic      [5:0] mux_field_out,
  output logic      [1:0] bias_sel_out,
  output logic      [2:0] temp_slope_setting_out,
  output logic      [2:0] osc_trim_out,
  output logic            quarter_bias_out,
  output logic      [1:0] phase_sel_out,
  output logic      [5:0] offset_out,
  output logic      [5:0] row_shift_out,
  // frame drive
  output logic            frame_pol_out,
  output logic            static_icon_drive_out,
  // memory pointers
  output logic      [7:0] col_addr_out,
  output logic      [3:0] page_addr_out,
  output logic            rmw_mode_out
);
  typedef struct packed {
    lcd_ext_pkg::cmd_state_e st;
    logic [5:0]  mux;
    logic [1:0]  bias;
    logic [2:0]  slope;
    logic [2:0]  osc;
    logic        qbias;
    logic [1:0]  phase;
    logic [5:0]  ofs;
    logic [5:0]  row_shift;
    logic [7:0]  col;
    logic [7:0]  col_save;
    logic [3:0]  page;
    logic        rmw;
    logic        fetch_pend;
    logic [7:0]  latch;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        busy;
    logic [15:0] div;
    logic [3:0]  ph_cnt;
    logic        pol;
    logic        icon_drv;
  } state_s;

  state_s q;
  state_s d;
  logic [7:0] mem_rdata;
  logic       mem_we;
  logic       is_read;
  logic       data_acc;
  logic       cmd_wr;

  function automatic logic host_reads(input logic [1:0] sel, input logic rw, input logic rd_n);
    case (sel)
      lcd_ext_pkg::IF_6800: host_reads = rw;
      lcd_ext_pkg::IF_8080: host_reads = ~rd_n;
      default:              host_reads = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] col_step(input logic [7:0] c);
    col_step = (c == lcd_ext_pkg::COL_MAX) ? c : c + 8'h01;
  endfunction

  function automatic logic [3:0] last_phase(input logic [1:0] sel);
    case (sel)
      2'h0:    last_phase = 4'h2;
      2'h1:    last_phase = 4'h4;
      2'h2:    last_phase = 4'h6;
      default: last_phase = 4'hF;
    endcase
  endfunction

  function automatic logic slope_legal(input logic [2:0] v);
    slope_legal = (v == 3'h0) || (v == 3'h2) || (v == 3'h4) || (v == 3'h7);
  endfunction

  assign is_read  = host_reads(port_sel_in, rw_in, rd_n_in);
  assign data_acc = xfer_stb_in & dc_in;
  assign cmd_wr   = xfer_stb_in & ~dc_in & ~is_read;
  assign mem_we   = data_acc & ~is_read;

  pix_mem #(
    .AW (12),
    .DW (8)
  ) u_mem (
    .sys_clk_in (sys_clk_in),
    .we_in      (mem_we),
    .addr_in    ({q.page, q.col}),
    .wdata_in   (data_in),
    .rdata_out  (mem_rdata)
  );

  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    d.busy     = 1'b0;
    if (q.fetch_pend) begin
      d.latch      = mem_rdata;
      d.fetch_pend = 1'b0;
    end
    if (data_acc) begin
      if (is_read) begin
        // answer carries the word fetched by the previous read, hence the dummy read
        d.rd_data    = q.fetch_pend ? mem_rdata : q.latch;
        d.rd_valid   = 1'b1;
        d.fetch_pend = 1'b1;
        d.busy       = 1'b1;
        if (!q.rmw) begin
          d.col = col_step(q.col);
        end
      end else begin
        d.col = col_step(q.col);
      end
    end else if (xfer_stb_in && is_read) begin
      d.rd_data  = {q.busy, 3'h0, lcd_ext_pkg::DEV_ID};
      d.rd_valid = 1'b1;
    end else if (cmd_wr) begin
      d.st = lcd_ext_pkg::ST_CMD;
      case (q.st)
        lcd_ext_pkg::ST_MUX: begin
          d.mux = data_in[5:0];
        end
        lcd_ext_pkg::ST_BIAS_TC: begin
          // prohibited and reserved codes are dropped so the drivers never see them
          if (data_in[1:0] != lcd_ext_pkg::BIAS_PROHIB) begin
            d.bias = data_in[1:0];
          end
          if (slope_legal(data_in[lcd_ext_pkg::SLOPE_LSB +: 3])) begin
            d.slope = data_in[lcd_ext_pkg::SLOPE_LSB +: 3];
          end
          d.osc = data_in[lcd_ext_pkg::OSC_LSB +: 3];
        end
        lcd_ext_pkg::ST_PHASE: begin
          if (!data_in[7] && data_in[4:0] == lcd_ext_pkg::PHASE_LOW) begin
            d.phase = data_in[lcd_ext_pkg::PHASE_LSB +: 2];
          end
        end
        lcd_ext_pkg::ST_OFFSET: begin
          d.ofs = data_in[5:0];
        end
        lcd_ext_pkg::ST_CMD: begin
          if (data_in == lcd_ext_pkg::OP_MUX) begin
            d.st = lcd_ext_pkg::ST_MUX;
          end else if (data_in == lcd_ext_pkg::OP_BIAS_TC) begin
            d.st = lcd_ext_pkg::ST_BIAS_TC;
          end else if (data_in == lcd_ext_pkg::OP_PHASE) begin
            d.st = lcd_ext_pkg::ST_PHASE;
          end else if (data_in == lcd_ext_pkg::OP_OFFSET) begin
            d.st = lcd_ext_pkg::ST_OFFSET;
          end else if (data_in[7:1] == lcd_ext_pkg::OP_QBIAS_TOP) begin
            d.qbias = data_in[0];
          end else if (data_in == lcd_ext_pkg::OP_RMW_ENTER) begin
            if (!q.rmw) begin
              d.col_save = q.col;
            end
            d.rmw = 1'b1;
          end else if (data_in == lcd_ext_pkg::OP_RMW_EXIT) begin
            if (q.rmw) begin
              d.col = q.col_save;
            end
            d.rmw = 1'b0;
          end else if (data_in == lcd_ext_pkg::OP_SOFT_RESET) begin
            d.col  = 8'h00;
            d.page = 4'h0;
          end else if (data_in[7:4] == lcd_ext_pkg::OP_COL_LO) begin
            d.col = {q.col[7:4], data_in[3:0]};
          end else if (data_in[7:4] == lcd_ext_pkg::OP_COL_HI) begin
            d.col = {data_in[3:0], q.col[3:0]};
          end else if (data_in[7:4] == lcd_ext_pkg::OP_PAGE) begin
            d.page = (data_in[3:0] > lcd_ext_pkg::PAGE_MAX) ? lcd_ext_pkg::PAGE_MAX : data_in[3:0];
          end
        end
        default: d.st = lcd_ext_pkg::ST_CMD;
      endcase
    end
    // a short mux with zero offset is centred in the 64-row matrix
    if (d.mux < lcd_ext_pkg::MUX_FIELD_64 && d.ofs == 6'h00) begin
      d.row_shift = (lcd_ext_pkg::ROWS_FULL - d.mux) >> 1;
    end else begin
      d.row_shift = d.ofs;
    end
    // phase sequencer: icon drive tracks polarity for the overlap phases only
    if (q.div == 16'(PHASE_DIV_P - 1)) begin
      d.div = 16'h0000;
      if (q.ph_cnt >= last_phase(q.phase)) begin
        d.ph_cnt = 4'h0;
        d.pol    = ~q.pol;
      end else begin
        d.ph_cnt = q.ph_cnt + 4'h1;
      end
    end else begin
      d.div = q.div + 16'h0001;
    end
    if (d.ph_cnt < (icon_on_in ? lcd_ext_pkg::OVL_ICON_ON : lcd_ext_pkg::OVL_ICON_OFF)) begin
      d.icon_drv = d.pol;
    end else begin
      d.icon_drv = ~d.pol;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q            <= '0;
      q.st         <= lcd_ext_pkg::ST_CMD;
      q.mux        <= lcd_ext_pkg::MUX_RST;
      q.bias       <= lcd_ext_pkg::BIAS_RST;
      q.slope      <= lcd_ext_pkg::SLOPE_RST;
      q.osc        <= lcd_ext_pkg::OSC_RST;
      q.qbias      <= lcd_ext_pkg::QBIAS_RST;
      q.phase      <= lcd_ext_pkg::PHASE_RST;
      q.ofs        <= lcd_ext_pkg::OFFSET_RST;
      // icon drive stays low with the polarity: phase 0 always overlaps, so no false mismatch after reset
    end else begin
      q <= d;
    end
  end

  assign rd_data_out            = q.rd_data;
  assign rd_valid_out           = q.rd_valid;
  assign busy_out               = q.busy;
  assign mux_field_out          = q.mux;
  assign bias_sel_out           = q.bias;
  assign temp_slope_setting_out = q.slope;
  assign osc_trim_out           = q.osc;
  assign quarter_bias_out       = q.qbias;
  assign phase_sel_out          = q.phase;
  assign offset_out             = q.ofs;
  assign row_shift_out          = q.row_shift;
  assign frame_pol_out          = q.pol;
  assign static_icon_drive_out  = q.icon_drv;
  assign col_addr_out           = q.col;
  assign page_addr_out          = q.page;
  assign rmw_mode_out           = q.rmw;

  AST_MUX_LOAD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_MUX |=> mux_field_out == $past(data_in[5:0]))
    else $error("multiplex field not loaded from parameter");
  AST_BIAS_LEGAL: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    bias_sel_out != lcd_ext_pkg::BIAS_PROHIB)
    else $error("prohibited bias value reached output");
  AST_SLOPE_LEGAL: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    slope_legal(temp_slope_setting_out))
    else $error("reserved slope code reached output");
  AST_OSC_LOAD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_BIAS_TC |=> osc_trim_out == $past(data_in[7:5]))
    else $error("oscillator trim not loaded");
  AST_QBIAS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_CMD && data_in[7:1] == lcd_ext_pkg::OP_QBIAS_TOP
    |=> quarter_bias_out == $past(data_in[0]))
    else $error("quarter bias not following command bit");
  AST_ICON_OVERLAP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    q.ph_cnt == 4'h0 |-> static_icon_drive_out == frame_pol_out)
    else $error("icon drive does not overlap polarity in first phase");
  AST_ROW_CENTER: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    mux_field_out < lcd_ext_pkg::MUX_FIELD_64 && offset_out == 6'h00
    |-> row_shift_out == 6'((lcd_ext_pkg::ROWS_FULL - mux_field_out) >> 1))
    else $error("short mux not centred");
  AST_SERIAL_NO_READ: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    xfer_stb_in && port_sel_in == lcd_ext_pkg::IF_SERIAL |=> !rd_valid_out)
    else $error("serial transfer produced a read answer");
  AST_RMW_READ_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    data_acc && is_read && rmw_mode_out |=> $stable(col_addr_out))
    else $error("column moved on read in read-modify-write mode");
  AST_WRITE_STEP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    mem_we && col_addr_out != lcd_ext_pkg::COL_MAX |=> col_addr_out == $past(col_addr_out) + 8'h01)
    else $error("data write did not advance column");
  AST_NO_WRAP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    data_acc && col_addr_out == lcd_ext_pkg::COL_MAX |=> col_addr_out == lcd_ext_pkg::COL_MAX)
    else $error("column wrapped past maximum");
  AST_RMW_SAVE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_CMD && data_in == lcd_ext_pkg::OP_RMW_ENTER && !rmw_mode_out
    |=> rmw_mode_out && q.col_save == $past(col_addr_out))
    else $error("column not saved on entering read-modify-write");
  AST_RMW_RESTORE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_CMD && data_in == lcd_ext_pkg::OP_RMW_EXIT && rmw_mode_out
    |=> !rmw_mode_out && col_addr_out == $past(q.col_save))
    else $error("column not restored at end of read-modify-write");
  AST_PARAM_NOT_CMD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st != lcd_ext_pkg::ST_CMD |=> q.st == lcd_ext_pkg::ST_CMD && $stable(rmw_mode_out))
    else $error("parameter byte decoded as command");

  COV_DATA_READ: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    data_acc && is_read ##1 rd_valid_out);
  COV_RMW_CYCLE: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    rmw_mode_out ##1 !rmw_mode_out);
  COV_OFFSET_LOAD: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cmd_wr && q.st == lcd_ext_pkg::ST_OFFSET);
  COV_COL_SATURATE: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    mem_we && col_addr_out == lcd_ext_pkg::COL_MAX);
endmodule
`default_nettype wire

// ---- sim/host_mcu_model.sv ----
// host microcontroller model driving the 6800, 8080 and serial host port
`default_nettype none
module host_mcu_model (
  // clock
  input  wire logic       sys_clk_in,
  // answer from the device
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  // host transfer
  output var  logic       xfer_stb_out,
  output var  logic [1:0] port_sel_out,
  output var  logic       dc_out,
  output var  logic       rw_out,
  output var  logic       rd_n_out,
  output var  logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    xfer_stb_out = 1'b0;
    port_sel_out = lcd_ext_pkg::IF_6800;
    dc_out       = 1'b0;
    rw_out       = 1'b0;
    rd_n_out     = 1'b1;
    data_out     = 8'h00;
  end
  // one access; the bench also issues undefined command bytes through it, such as 8'hE3
  task automatic xfer(input logic [1:0] port, input logic dc, input logic rd, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(posedge sys_clk_in);
    #1;
    xfer_stb_out = 1'b1;
    port_sel_out = port;
    dc_out       = dc;
    rw_out       = rd;
    rd_n_out     = ~rd;
    data_out     = d;
    @(posedge sys_clk_in);
    #1;
    q            = rd_data_in;
    v            = rd_valid_in;
    xfer_stb_out = 1'b0;
    rd_n_out     = 1'b1;
    // released bus shows the inverse so a stale byte cannot pass for a fresh one
    data_out     = ~d;
  endtask
endmodule
`default_nettype wire

// ---- sim/lcd_ext_cmd_and_ram_access_tb.sv ----
// self-checking bench for the extended command decoder and pixel-memory access
`default_nettype none
module lcd_ext_cmd_and_ram_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  localparam logic [1:0] P68 = lcd_ext_pkg::IF_6800;
  localparam logic [1:0] P80 = lcd_ext_pkg::IF_8080;
  localparam logic [1:0] PSR = lcd_ext_pkg::IF_SERIAL;
  logic       sys_clk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       icon_on_in = 1'b0;
  logic       xfer_stb, dc, rw, rd_n, rd_valid, busy, qb, pol, drive, rmw;
  logic [1:0] port_sel, bias, phase;
  logic [2:0] tslope, osc;
  logic [3:0] page;
  logic [5:0] mux, offset, rshift;
  logic [7:0] data, rd_data, col, q;
  logic       v;
  int         miscompares = 0;
  int         checks = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  lcd_ext_cmd #(.PHASE_DIV_P(DIV)) u_dut (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .xfer_stb_in(xfer_stb), .port_sel_in(port_sel),
    .dc_in(dc), .rw_in(rw), .rd_n_in(rd_n), .data_in(data), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .busy_out(busy), .icon_on_in(icon_on_in), .mux_field_out(mux), .bias_sel_out(bias),
    .temp_slope_setting_out(tslope), .osc_trim_out(osc), .quarter_bias_out(qb), .phase_sel_out(phase),
    .offset_out(offset), .row_shift_out(rshift), .frame_pol_out(pol), .static_icon_drive_out(drive),
    .col_addr_out(col), .page_addr_out(page), .rmw_mode_out(rmw));
  host_mcu_model u_host (
    .sys_clk_in(sys_clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .xfer_stb_out(xfer_stb),
    .port_sel_out(port_sel), .dc_out(dc), .rw_out(rw), .rd_n_out(rd_n), .data_out(data));
  task automatic check(input logic [7:0] s, input logic [7:0] e, input string m);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.xfer(P68, 1'b0, 1'b0, b, q, v);
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] b);
    u_host.xfer(p, 1'b1, 1'b0, b, q, v);
  endtask
  task automatic rd(input logic [1:0] p, output logic [7:0] d);
    u_host.xfer(p, 1'b1, 1'b1, 8'h00, d, v);
    check({7'h00, v}, 8'h01, "read valid");
    check({7'h00, busy}, 8'h01, "busy after read");
  endtask
  task automatic set_col(input logic [7:0] c, input logic [3:0] p);
    cmd({4'h0, c[3:0]});
    cmd({4'h1, c[7:4]});
    cmd({4'hB, p});
  endtask
  task automatic defaults();
    check({2'h0, mux}, 8'h3F, "mux");
    check({6'h0, bias}, 8'h02, "bias");
    check({5'h0, tslope}, 8'h00, "slope");
    check({5'h0, osc}, 8'h03, "osc");
    check({7'h0, qb}, 8'h00, "quarter");
    check({6'h0, phase}, 8'h02, "phase");
    check({2'h0, offset}, 8'h00, "offset");
  endtask
  function automatic logic [2:0] exp_slope(input logic [2:0] old, input logic [2:0] t);
    return (t == 3'h0 || t == 3'h2 || t == 3'h4 || t == 3'h7) ? t : old;
  endfunction
  task automatic frame(input int n, input int ov);
    int k, len, cnt;
    logic p0;
    for (int f = 0; f < 2; f++) begin
      p0 = pol;
      len = 0;
      cnt = 0;
      for (k = 0; k < 300 && pol === p0; k++) begin
        cnt += (drive === pol);
        len++;
        @(posedge sys_clk_in);
        #1;
      end
      if (k == 300) begin
        miscompares++;
        end_of_test();
      end
    end
    check(len[7:0], n[7:0], "frame length");
    check(cnt[7:0], ov[7:0], "icon overlap");
  endtask
  logic [7:0] d [4];
  logic [2:0] et, o;
  logic [1:0] eb;
  logic [5:0] f;
  initial begin
    void'($urandom(32'h0368));
    repeat (3) @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    defaults();
    $display("test reset defaults done");
    f = 6'($urandom_range(0, 63));
    cmd(lcd_ext_pkg::OP_MUX);
    cmd({2'h0, f});
    check({2'h0, mux}, {2'h0, f}, "mux");
    cmd(lcd_ext_pkg::OP_MUX);
    cmd(lcd_ext_pkg::OP_OFFSET);
    check({2'h0, mux}, 8'h13, "mux param");
    check({2'h0, offset}, 8'h00, "param not opcode");
    $display("test multiplex done");
    eb = 2'h2;
    et = 3'h0;
    for (int i = 0; i < 32; i++) begin
      o = 3'($urandom);
      cmd(lcd_ext_pkg::OP_BIAS_TC);
      cmd({o, 3'(i >> 2), 2'(i)});
      eb = (2'(i) == 2'h3) ? eb : 2'(i);
      et = exp_slope(et, 3'(i >> 2));
      check({6'h0, bias}, {6'h0, eb}, "bias");
      check({5'h0, tslope}, {5'h0, et}, "slope");
      check({5'h0, osc}, {5'h0, o}, "osc");
    end
    cmd(8'hAB);
    check({7'h0, qb}, 8'h01, "quarter on");
    cmd(8'hAA);
    check({7'h0, qb}, 8'h00, "quarter off");
    $display("test bias done");
    for (int s = 0; s < 4; s++) begin
      cmd(lcd_ext_pkg::OP_PHASE);
      cmd({1'b0, 2'(s), 5'h02});
      check({6'h0, phase}, 8'(s), "phase");
    end
    cmd(lcd_ext_pkg::OP_PHASE);
    cmd(8'h82);
    cmd(lcd_ext_pkg::OP_PHASE);
    cmd(8'h04);
    check({6'h0, phase}, 8'h03, "bad phase byte");
    for (int i = 0; i < 4; i++) begin
      cmd(lcd_ext_pkg::OP_PHASE);
      cmd(i[1] ? 8'h62 : 8'h02);
      icon_on_in = i[0];
      frame((i[1] ? 16 : 3) * DIV, (i[0] ? 3 : 1) * DIV);
    end
    $display("test frame phases done");
    cmd(lcd_ext_pkg::OP_MUX);
    cmd(8'h10);
    check({2'h0, rshift}, 8'h17, "centred");
    f = 6'($urandom_range(1, 23));
    f = $urandom_range(0, 1) ? f : 6'(64 - f);
    cmd(lcd_ext_pkg::OP_OFFSET);
    cmd({2'h0, f});
    check({2'h0, offset}, {2'h0, f}, "offset");
    check({2'h0, rshift}, {2'h0, f}, "row shift");
    $display("test offset done");
    set_col(8'h10, 4'h2);
    wr(P68, 8'h5A);
    check(col, 8'h11, "col write");
    check({4'h0, page}, 8'h02, "page");
    cmd(8'hE3);
    u_host.xfer(P68, 1'b0, 1'b1, 8'h00, q, v);
    check(q, {4'h0, lcd_ext_pkg::DEV_ID}, "status");
    check(col, 8'h11, "col cmd status");
    wr(P80, 8'h11);
    wr(PSR, 8'h22);
    u_host.xfer(PSR, 1'b1, 1'b1, 8'h00, q, v);
    check({7'h0, v}, 8'h00, "serial no read");
    check(col, 8'h14, "col 8080 serial");
    set_col(8'h20, 4'h2);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
      wr(P68, d[i]);
    end
    set_col(8'h20, 4'h2);
    rd(P80, q);
    for (int i = 0; i < 3; i++) begin
      rd(i[0] ? P80 : P68, q);
      check(q, d[i], "read data");
    end
    check(col, 8'h24, "col read");
    set_col(8'h20, 4'h2);
    cmd(lcd_ext_pkg::OP_RMW_ENTER);
    check({7'h0, rmw}, 8'h01, "rmw on");
    rd(P68, q);
    rd(P68, q);
    check(q, d[0], "rmw read");
    check(col, 8'h20, "rmw col held");
    wr(P68, 8'hA5);
    check(col, 8'h21, "rmw write bumps");
    cmd(lcd_ext_pkg::OP_RMW_EXIT);
    check(col, 8'h20, "rmw restore");
    check({7'h0, rmw}, 8'h00, "rmw off");
    rd(P68, q);
    rd(P68, q);
    check(q, 8'hA5, "modified byte");
    set_col(8'h82, 4'h0);
    repeat (3) wr(P68, 8'h00);
    check(col, 8'h83, "col saturate");
    $display("test pointers done");
    @(posedge sys_clk_in);
    #1 arst_n_in = 1'b0;
    @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    defaults();
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
